// file: sci_defines.vh
// Purpose: Constants for the command decode block of the stacked low-power DRAM
// Assumes: Included by its bare name from every file except the two-entry buffer
// Notes:   Definitions only
`ifndef SCI_DEFINES_VH
`define SCI_DEFINES_VH

// ============================================================
// Command encodings {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n}
`define SCI_CMD_NOP        4'h7
`define SCI_CMD_ROW_OPEN   4'h3
`define SCI_CMD_READ       4'h5
`define SCI_CMD_WRITE      4'h4
`define SCI_CMD_BURST_STOP 4'h6
`define SCI_CMD_PRECHARGE  4'h2
`define SCI_CMD_REFRESH    4'h1
`define SCI_CMD_MODE_LOAD  4'h0

// ============================================================
// Decoded operation codes carried in the command word
`define SCI_OP_ROW_OPEN    4'h1
`define SCI_OP_READ        4'h2
`define SCI_OP_WRITE       4'h3
`define SCI_OP_BURST_TERM  4'h4
`define SCI_OP_DEEP_PD     4'h5
`define SCI_OP_PRECHARGE   4'h6
`define SCI_OP_PRE_ALL     4'h7
`define SCI_OP_AUTO_REF    4'h8
`define SCI_OP_SELF_REF    4'h9
`define SCI_OP_MODE_LOAD   4'ha
`define SCI_OP_EXT_LOAD    4'hb

// ============================================================
// Command word layout
`define SCI_WORD_W         20
`define SCI_WORD_OP_LSB    16
`define SCI_WORD_BANK_LSB  14
`define SCI_WORD_ADDR_LSB  1
`define SCI_WORD_AUTOPRE   0

// ============================================================
// Main mode register fields
`define SCI_MR_BL_LSB      0
`define SCI_MR_BT_BIT      3
`define SCI_MR_RL_LSB      4
`define SCI_MR_WBM_BIT     9
// Extended register fields
`define SCI_EMR_PARTIAL_ARRAY_REFRESH_FIELD_LSB   0
`define SCI_EMR_TEMP_COMP_REFRESH_FIELD_LSB   3
`define SCI_TEMP_COMP_REFRESH_FIELD_SENSOR    2'h0

// ============================================================
// Reset values
`define SCI_MR_RESET       13'h0000
`define SCI_EMR_RESET      13'h0000
`define SCI_REF_CNT_RESET  15'h0000

// ============================================================
// Read mask to high impedance latency in memory clocks
`define SCI_DQM_RD_LAT     2

`endif

// file: sci_buf2.v
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, synchronous active-low reset
// Notes:   Full and empty are exact; read data come from registers
`timescale 1ns/1ps
module sci_buf2 #(
  parameter W = 20
) (
  input  wire         sys_clk_i,
  input  wire         nrst_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);

  reg [W-1:0] slot0_q;
  reg [W-1:0] slot1_q;
  reg [1:0]   count_q;

  wire push = in_valid_i & in_ready_o;
  wire pop  = out_valid_o & out_ready_i;

  assign in_ready_o  = (count_q != 2'h2);
  assign out_valid_o = (count_q != 2'h0);
  assign out_data_o  = slot0_q;

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      slot0_q <= {W{1'b0}};
      slot1_q <= {W{1'b0}};
      count_q <= 2'h0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count_q == 2'h0) slot0_q <= in_data_i;
          else slot1_q <= in_data_i;
          count_q <= count_q + 2'h1;
        end
        2'b01: begin
          slot0_q <= slot1_q;
          count_q <= count_q - 2'h1;
        end
        2'b11: begin
          if (count_q == 2'h1) slot0_q <= in_data_i;
          else begin
            slot0_q <= slot1_q;
            slot1_q <= in_data_i;
          end
        end
        default: begin
        end
      endcase
    end
  end

endmodule // sci_buf2

// file: sci_command_interface.v
// Purpose: Command decode and bank state of one die of a stacked DRAM
// Assumes: Memory clock and command pins are asynchronous to sys_clk_i and
//          much slower; they are sampled and the rising memory clock edge found
// Notes:   Decoded commands leave through a two-entry buffer
//
// Summary of operation
// - Sensor on only when temperature field is 00
// - Decode eight command encodings from strobes
// - Deselect acts exactly like no-operation
// - Selected no-operation disturbs nothing under way
// - Row open takes bank bits, row bits 0-12
// - Read/write take column 0-8, flag autoprecharge
// - Burst stop: terminate, or deep power-down
// - Precharge one bank, or all when flagged
// - Refresh encoding: auto, or self-refresh entry
// - Refresh addresses come from internal counter
// - Mode load picks main or extended register
// - Mask discards writes, tristates reads after two
// - All inputs taken on rising memory clock
// - Main register: length, type, latency, write mode
// - Extended register: partial array, temperature field
`timescale 1ns/1ps
`include "sci_defines.vh"
module sci_command_interface (
  input  wire        sys_clk_i,
  input  wire        nrst_i,
  input  wire        mem_clk_i,
  input  wire        clk_en_pin_i,
  input  wire        chip_select_n_i,
  input  wire        row_strobe_n_i,
  input  wire        column_strobe_n_i,
  input  wire        write_strobe_n_i,
  input  wire        data_mask_i,
  input  wire [12:0] addr_i,
  input  wire        bank_sel0_i,
  input  wire        bank_sel1_i,
  output wire        cmd_valid_o,
  input  wire        cmd_ready_i,
  output wire [19:0] cmd_word_o,
  output wire        cmd_stall_o,
  output reg         write_mask_o,
  output reg         read_hiz_o,
  output reg  [3:0]  bank_open_o,
  output reg  [51:0] bank_rows_o,
  output reg  [2:0]  burst_len_o,
  output reg         burst_type_o,
  output reg  [2:0]  read_lat_o,
  output reg         write_single_o,
  output reg  [2:0]  partial_array_refresh_field_o,
  output reg  [1:0]  temp_comp_refresh_field_o,
  output reg         temp_sensor_en_o,
  output reg         self_refresh_o,
  output reg         deep_power_down_o,
  output reg  [14:0] refresh_count_o
);

  // ============================================================
  // Pin sampling: three stages, change counted when stages 2 and 3 agree
  localparam PW = 22;
  wire [PW-1:0] pins = {mem_clk_i, clk_en_pin_i, chip_select_n_i, row_strobe_n_i,
                        column_strobe_n_i, write_strobe_n_i, data_mask_i,
                        addr_i, bank_sel1_i, bank_sel0_i};
  reg  [PW-1:0] sync1_q;
  reg  [PW-1:0] sync2_q;
  reg  [PW-1:0] sync3_q;
  reg           mclk_lvl_q;

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      sync1_q    <= {PW{1'b0}};
      sync2_q    <= {PW{1'b0}};
      sync3_q    <= {PW{1'b0}};
      mclk_lvl_q <= 1'b0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q[PW-1] == sync3_q[PW-1])
        mclk_lvl_q <= sync3_q[PW-1];
    end
  end

  wire        mclk_rise = sync2_q[PW-1] & sync3_q[PW-1] & ~mclk_lvl_q;
  wire        s_cke     = sync3_q[20];
  wire [3:0]  s_cmd     = sync3_q[19:16];
  wire        s_dqm     = sync3_q[15];
  wire [12:0] s_addr    = sync3_q[14:2];
  wire [1:0]  s_bank    = sync3_q[1:0];
  wire        s_flag    = s_addr[10];

  // ============================================================
  // Power state machine
  localparam ST_ACTIVE = 3'b001;
  localparam ST_SELF   = 3'b010;
  localparam ST_DEEP   = 3'b100;
  reg [2:0] pwr_q;

  // ============================================================
  // Command decode
  reg [3:0]  op;
  reg        op_en;
  reg [12:0] op_addr;
  reg [1:0]  op_bank;

  always @* begin
    op      = 4'h0;
    op_en   = 1'b0;
    op_addr = s_addr;
    op_bank = s_bank;
    if (pwr_q == ST_ACTIVE) begin
      case (s_cmd)
        `SCI_CMD_ROW_OPEN: begin
          op    = `SCI_OP_ROW_OPEN;
          op_en = 1'b1;
        end
        `SCI_CMD_READ: begin
          op      = `SCI_OP_READ;
          op_en   = 1'b1;
          op_addr = {4'h0, s_addr[8:0]};
        end
        `SCI_CMD_WRITE: begin
          op      = `SCI_OP_WRITE;
          op_en   = 1'b1;
          op_addr = {4'h0, s_addr[8:0]};
        end
        `SCI_CMD_BURST_STOP: begin
          op    = s_cke ? `SCI_OP_BURST_TERM : `SCI_OP_DEEP_PD;
          op_en = 1'b1;
        end
        `SCI_CMD_PRECHARGE: begin
          op    = s_flag ? `SCI_OP_PRE_ALL : `SCI_OP_PRECHARGE;
          op_en = 1'b1;
        end
        `SCI_CMD_REFRESH: begin
          op      = s_cke ? `SCI_OP_AUTO_REF : `SCI_OP_SELF_REF;
          op_en   = 1'b1;
          op_addr = refresh_count_o[12:0];
          op_bank = refresh_count_o[14:13];
        end
        `SCI_CMD_MODE_LOAD: begin
          op_en = (s_bank == 2'h0) | (s_bank == 2'h2);
          op    = s_bank[1] ? `SCI_OP_EXT_LOAD : `SCI_OP_MODE_LOAD;
        end
        default: begin
          // Deselect and no-operation: nothing taken, state untouched
          op_en = 1'b0;
        end
      endcase
    end
  end

  wire       take   = mclk_rise & op_en;
  wire       autopre = s_flag & ((op == `SCI_OP_READ) | (op == `SCI_OP_WRITE));
  wire [19:0] word  = {op, op_bank, op_addr, autopre};
  wire        buf_ready;
  reg         pend_q;
  reg  [19:0] pend_word_q;

  // ============================================================
  // State updates on each rising memory clock and on accepted commands
  reg [1:0] dqm_pipe_q;
  integer   b;

  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pwr_q                         <= ST_ACTIVE;
      bank_open_o                   <= 4'h0;
      bank_rows_o                   <= 52'h0;
      {burst_len_o, burst_type_o, read_lat_o, write_single_o} <= 8'h00;
      partial_array_refresh_field_o <= 3'h0;
      temp_comp_refresh_field_o     <= 2'h0;
      temp_sensor_en_o              <= 1'b1;
      refresh_count_o               <= `SCI_REF_CNT_RESET;
      write_mask_o                  <= 1'b0;
      read_hiz_o                    <= 1'b0;
      dqm_pipe_q                    <= 2'h0;
      self_refresh_o                <= 1'b0;
      deep_power_down_o             <= 1'b0;
      pend_q                        <= 1'b0;
      pend_word_q                   <= 20'h00000;
    end else begin
      if (pend_q & buf_ready)
        pend_q <= 1'b0;
      if (mclk_rise) begin
        dqm_pipe_q   <= {dqm_pipe_q[0], s_dqm};
        read_hiz_o   <= dqm_pipe_q[`SCI_DQM_RD_LAT-1];
        write_mask_o <= s_dqm;
        case (pwr_q)
          ST_SELF: if (s_cke) pwr_q <= ST_ACTIVE;
          ST_DEEP: if (s_cke) pwr_q <= ST_ACTIVE;
          default: pwr_q <= ST_ACTIVE;
        endcase
        if (pwr_q != ST_ACTIVE) begin
          if (s_cke) begin
            self_refresh_o    <= 1'b0;
            deep_power_down_o <= 1'b0;
          end
        end
      end
      if (take) begin
        if (!(buf_ready & ~pend_q)) begin
          pend_q      <= 1'b1;
          pend_word_q <= word;
        end
        case (op)
          `SCI_OP_ROW_OPEN: begin
            bank_open_o[s_bank] <= 1'b1;
            for (b = 0; b < 4; b = b + 1)
              if (s_bank == b[1:0])
                bank_rows_o[b*13 +: 13] <= s_addr;
          end
          `SCI_OP_READ, `SCI_OP_WRITE:
            if (s_flag) bank_open_o[s_bank] <= 1'b0;
          `SCI_OP_PRECHARGE: bank_open_o[s_bank] <= 1'b0;
          `SCI_OP_PRE_ALL:   bank_open_o <= 4'h0;
          `SCI_OP_AUTO_REF:
            refresh_count_o <= refresh_count_o + 15'h0001;
          `SCI_OP_SELF_REF: begin
            pwr_q           <= ST_SELF;
            self_refresh_o  <= 1'b1;
            refresh_count_o <= refresh_count_o + 15'h0001;
          end
          `SCI_OP_DEEP_PD: begin
            pwr_q             <= ST_DEEP;
            deep_power_down_o <= 1'b1;
          end
          `SCI_OP_MODE_LOAD: begin
            burst_len_o    <= s_addr[`SCI_MR_BL_LSB +: 3];
            burst_type_o   <= s_addr[`SCI_MR_BT_BIT];
            read_lat_o     <= s_addr[`SCI_MR_RL_LSB +: 3];
            write_single_o <= s_addr[`SCI_MR_WBM_BIT];
          end
          `SCI_OP_EXT_LOAD: begin
            partial_array_refresh_field_o <= s_addr[`SCI_EMR_PARTIAL_ARRAY_REFRESH_FIELD_LSB +: 3];
            temp_comp_refresh_field_o     <= s_addr[`SCI_EMR_TEMP_COMP_REFRESH_FIELD_LSB +: 2];
            temp_sensor_en_o <= (s_addr[`SCI_EMR_TEMP_COMP_REFRESH_FIELD_LSB +: 2] == `SCI_TEMP_COMP_REFRESH_FIELD_SENSOR);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ============================================================
  // Output buffer; a word refused by a full buffer waits in the pending slot
  wire        buf_in_valid = pend_q | take;
  wire [19:0] buf_in_data  = pend_q ? pend_word_q : word;

  assign cmd_stall_o = pend_q;

  sci_buf2 #(
    .W(`SCI_WORD_W)
  ) u_buf (
    .sys_clk_i   (sys_clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (buf_in_valid),
    .in_ready_o  (buf_ready),
    .in_data_i   (buf_in_data),
    .out_valid_o (cmd_valid_o),
    .out_ready_i (cmd_ready_i),
    .out_data_o  (cmd_word_o)
  );

endmodule // sci_command_interface

// file: sci_ci_sva.sv
// Purpose: Assertions on the command decode outputs
// Assumes: Bound to sci_command_interface
// Notes:   Fresh-word checks need an empty buffer
`timescale 1ns/1ps
`include "sci_defines.vh"
module sci_ci_sva (
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  input wire logic        cmd_valid_o,
  input wire logic        cmd_ready_i,
  input wire logic [19:0] cmd_word_o,
  input wire logic        cmd_stall_o,
  input wire logic [3:0]  bank_open_o,
  input wire logic [51:0] bank_rows_o,
  input wire logic [14:0] refresh_count_o,
  input wire logic [2:0]  burst_len_o,
  input wire logic        burst_type_o,
  input wire logic [2:0]  read_lat_o,
  input wire logic        write_single_o,
  input wire logic [2:0]  partial_array_refresh_field_o,
  input wire logic [1:0]  temp_comp_refresh_field_o,
  input wire logic        temp_sensor_en_o,
  input wire logic        self_refresh_o,
  input wire logic        deep_power_down_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  logic       was_v_q;
  wire [3:0]  op = cmd_word_o[19:16];
  wire [1:0]  bk = cmd_word_o[15:14];
  wire        nw = cmd_valid_o & ~was_v_q;
  always @(posedge sys_clk_i) was_v_q <= nrst_i & cmd_valid_o;
  // ============================================================
  // Word stream and decoded state
  a_sensor_follows: assert property (temp_sensor_en_o == (temp_comp_refresh_field_o == 2'h0))
    else $error("sensor enable wrong");
  a_op_legal: assert property (cmd_valid_o |-> op inside {[4'h1:4'hb]})
    else $error("illegal op");
  a_word_hold: assert property (cmd_valid_o && !cmd_ready_i |=> cmd_valid_o && $stable(cmd_word_o))
    else $error("word not held");
  a_stall_full: assert property (cmd_stall_o |-> cmd_valid_o [*2])
    else $error("stall without words");
  a_row_open: assert property (nw && op == `SCI_OP_ROW_OPEN |-> bank_open_o[bk] &&
    bank_rows_o[bk*13 +: 13] == cmd_word_o[13:1]) else $error("row open state");
  a_col_width: assert property (cmd_valid_o && op inside {4'h2, 4'h3} |-> cmd_word_o[13:10] == 4'h0)
    else $error("column too wide");
  a_autopre_close: assert property (nw && op inside {4'h2, 4'h3} && cmd_word_o[0] |-> !bank_open_o[bk])
    else $error("autoprecharge kept bank");
  a_pre_one: assert property (nw && op == `SCI_OP_PRECHARGE |-> !bank_open_o[bk])
    else $error("bank not closed");
  a_pre_all: assert property (nw && op == `SCI_OP_PRE_ALL |-> bank_open_o == 4'h0)
    else $error("banks not closed");
  a_deep_entry: assert property (nw && op == `SCI_OP_DEEP_PD |-> deep_power_down_o)
    else $error("no deep power down");
  a_self_entry: assert property (nw && op == `SCI_OP_SELF_REF |-> self_refresh_o)
    else $error("no self refresh");
  a_refresh_count: assert property (nw && op == `SCI_OP_AUTO_REF |->
    refresh_count_o == cmd_word_o[15:1] + 15'h1) else $error("refresh counter");
  a_main_fields: assert property (nw && op == `SCI_OP_MODE_LOAD |->
    {burst_len_o, burst_type_o, read_lat_o, write_single_o} ==
    {cmd_word_o[3:1], cmd_word_o[4], cmd_word_o[7:5], cmd_word_o[10]}) else $error("main fields");
  a_ext_fields: assert property (nw && op == `SCI_OP_EXT_LOAD |->
    {temp_comp_refresh_field_o, partial_array_refresh_field_o} == cmd_word_o[5:1])
    else $error("extended fields");
endmodule // sci_ci_sva

bind sci_command_interface sci_ci_sva i_sci_ci_sva (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
  .cmd_word_o(cmd_word_o), .cmd_stall_o(cmd_stall_o), .bank_open_o(bank_open_o),
  .bank_rows_o(bank_rows_o), .refresh_count_o(refresh_count_o), .burst_len_o(burst_len_o),
  .burst_type_o(burst_type_o), .read_lat_o(read_lat_o), .write_single_o(write_single_o),
  .partial_array_refresh_field_o(partial_array_refresh_field_o),
  .temp_comp_refresh_field_o(temp_comp_refresh_field_o), .temp_sensor_en_o(temp_sensor_en_o),
  .self_refresh_o(self_refresh_o), .deep_power_down_o(deep_power_down_o));

// file: sci_ctrl_model.sv
// Purpose: Memory controller model driving the command pins
// Assumes: Free-running memory clock, 64 ns period
// Notes:   Pads commands with no-operations to keep spacings
`timescale 1ns/1ps
`include "sci_defines.vh"
module sci_ctrl_model (
  output logic        mem_clk_o,
  output logic        cke_o,
  output logic [3:0]  cmd_n_o,
  output logic        dqm_o,
  output logic [12:0] addr_o,
  output logic [1:0]  bank_o
);
  localparam int TCK = 64;
  int cyc = 0;
  int mrs_at = -9;
  int any_act = -9;
  int act_at[4] = '{-9, -9, -9, -9};
  function automatic int cycles(input int ns);
    return (ns + TCK - 1) / TCK;
  endfunction
  initial begin
    {cke_o, cmd_n_o, dqm_o, addr_o, bank_o} = {1'b1, `SCI_CMD_NOP, 16'h0};
    mem_clk_o = 1'b0;
    forever #(TCK / 2) mem_clk_o = ~mem_clk_o;
  end
  task automatic step(input logic [3:0] c, input logic [12:0] a, input logic [1:0] b,
                      input logic ck, input logic dm);
    @(negedge mem_clk_o);
    {cmd_n_o, addr_o, bank_o, cke_o, dqm_o} = {c, a, b, ck, dm};
    @(posedge mem_clk_o);
    cyc++;
  endtask
  task automatic cmd(input logic [3:0] c, input logic [12:0] a, input logic [1:0] b,
                     input logic ck, input logic dm);
    while (cyc + 1 - mrs_at < 2 ||
           (c == `SCI_CMD_ROW_OPEN && (cyc + 1 - act_at[b] < cycles(67) ||
            cyc + 1 - any_act < cycles(15))) ||
           ((c == `SCI_CMD_READ || c == `SCI_CMD_WRITE) && cyc + 1 - act_at[b] < cycles(19)))
      step(`SCI_CMD_NOP, ~addr_o, ~bank_o, 1'b1, dm);
    step(c, a, b, ck, dm);
    if (c == `SCI_CMD_MODE_LOAD) mrs_at = cyc;
    if (c == `SCI_CMD_ROW_OPEN) {act_at[b], any_act} = {cyc, cyc};
  endtask
endmodule // sci_ctrl_model

// file: sci_command_interface_bench.sv
// Purpose: Self-checking bench for the command decode block
// Assumes: Controller model drives all memory pins
// Notes:   Random consumer stalls the word stream
`timescale 1ns/1ps
`include "sci_defines.vh"
module sci_command_interface_bench;
  localparam logic [19:0] MF = 20'hffffe, MA = 20'hfffff, MO = 20'hf0000, MB = 20'hfc000;
  logic        sys_clk_i, nrst_i, ready, hold, mem_clk, cke, dqm, valid, stall, wmask, rhiz;
  logic [3:0]  cmd_n, bopen, open_m = 4'h0;
  logic [12:0] addr, a;
  logic [1:0]  bank, lp;
  logic [19:0] word;
  logic [51:0] rows, rows_m;
  logic [14:0] rcnt, rc_m = 15'h0;
  logic [7:0]  mr;
  logic [5:0]  em;
  logic [39:0] e, expq[$];
  int          errors = 0, compares = 0, cyc = 0, k;
  sci_ctrl_model i_sci_ctrl_model (.mem_clk_o(mem_clk), .cke_o(cke), .cmd_n_o(cmd_n),
    .dqm_o(dqm), .addr_o(addr), .bank_o(bank));
  sci_command_interface i_sci_command_interface (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .mem_clk_i(mem_clk), .clk_en_pin_i(cke), .chip_select_n_i(cmd_n[3]),
    .row_strobe_n_i(cmd_n[2]), .column_strobe_n_i(cmd_n[1]), .write_strobe_n_i(cmd_n[0]),
    .data_mask_i(dqm), .addr_i(addr), .bank_sel0_i(bank[0]), .bank_sel1_i(bank[1]),
    .cmd_valid_o(valid), .cmd_ready_i(ready), .cmd_word_o(word), .cmd_stall_o(stall),
    .write_mask_o(wmask), .read_hiz_o(rhiz), .bank_open_o(bopen), .bank_rows_o(rows),
    .burst_len_o(mr[7:5]), .burst_type_o(mr[4]), .read_lat_o(mr[3:1]), .write_single_o(mr[0]),
    .partial_array_refresh_field_o(em[5:3]), .temp_comp_refresh_field_o(em[2:1]),
    .temp_sensor_en_o(em[0]), .self_refresh_o(lp[1]), .deep_power_down_o(lp[0]),
    .refresh_count_o(rcnt));
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // ============================================================
  // Checking, consumer and timeout
  task chk(input logic [55:0] seen, input logic [55:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(negedge sys_clk_i) ready <= !hold && $urandom_range(1);
  always @(posedge sys_clk_i) begin
    if (valid === 1'b1 && ready) begin
      e = expq.size() ? expq.pop_front() : 40'hfffff00000;
      chk(word & e[39:20], e[19:0] & e[39:20]);
    end
    if (++cyc == 20000) begin
      errors++;
      stop_test;
    end
  end
  // ============================================================
  // Stimulus helpers
  task automatic op(input logic [3:0] c, input logic [12:0] a, input logic [1:0] b,
                    input logic ck, input logic dm, input logic [3:0] o, input logic [19:0] m);
    logic [12:0] aw;
    aw = (o == `SCI_OP_READ || o == `SCI_OP_WRITE) ? {4'h0, a[8:0]} : a;
    i_sci_ctrl_model.cmd(c, a, b, ck, dm);
    if (o != 4'h0) expq.push_back({m, o, b, aw, a[10]});
    repeat (6) @(negedge sys_clk_i);
  endtask
  task automatic open_all;
    for (int j = 0; j < 4; j++) if (!open_m[j]) begin
      a = 13'($urandom);
      op(`SCI_CMD_ROW_OPEN, a, j[1:0], 1'b1, 1'b0, `SCI_OP_ROW_OPEN, MF);
      open_m[j] = 1'b1;
      rows_m[j*13 +: 13] = a;
    end
  endtask
  task automatic drain;
    for (int i = 0; i < 400 && expq.size() != 0; i++) @(negedge sys_clk_i);
  endtask
  // ============================================================
  // Main sequence
  initial begin
    void'($urandom(32'h6d70f3cb));
    {nrst_i, ready, hold} = 3'b000;
    repeat (3) @(negedge sys_clk_i);
    nrst_i = 1'b1;
    chk({valid, bopen, em[0]}, 6'h01);
    a = 13'($urandom);
    op(`SCI_CMD_MODE_LOAD, a, 2'b00, 1'b1, 1'b0, `SCI_OP_MODE_LOAD, MF);
    chk(mr, {a[2:0], a[3], a[6:4], a[9]});
    for (int t = 0; t < 4; t++) begin
      a = 13'($urandom);
      a[4:3] = t[1:0];
      op(`SCI_CMD_MODE_LOAD, a, 2'b10, 1'b1, 1'b0, `SCI_OP_EXT_LOAD, MF);
      chk(em, {a[2:0], a[4:3], t == 0});
    end
    op(`SCI_CMD_MODE_LOAD, ~a, 2'b01, 1'b1, 1'b0, 4'h0, 20'h0);
    op(`SCI_CMD_MODE_LOAD, ~a, 2'b11, 1'b1, 1'b0, 4'h0, 20'h0);
    chk(em, {a[2:0], a[4:3], 1'b0});
    open_all;
    chk({bopen, rows}, {open_m, rows_m});
    for (int i = 0; i < 6; i++) begin
      op(i[0] ? 4'h8 | 4'($urandom) : `SCI_CMD_NOP, 13'($urandom), 2'($urandom),
         1'b1, 1'b0, 4'h0, 20'h0);
      chk({bopen, rows}, {open_m, rows_m});
    end
    for (int i = 0; i < 10; i++) begin
      open_all;
      k = $urandom_range(3);
      a = 13'($urandom);
      op(i[0] ? `SCI_CMD_READ : `SCI_CMD_WRITE, a, k[1:0], 1'b1, 1'b0,
         i[0] ? `SCI_OP_READ : `SCI_OP_WRITE, MA);
      if (a[10]) open_m[k] = 1'b0;
      chk(bopen, open_m);
    end
    open_all;
    k = $urandom_range(3);
    op(`SCI_CMD_PRECHARGE, 13'($urandom) & 13'h1bff, k[1:0], 1'b1, 1'b0, `SCI_OP_PRECHARGE, MB);
    open_m[k] = 1'b0;
    chk(bopen, open_m);
    op(`SCI_CMD_PRECHARGE, 13'h0400, 2'($urandom), 1'b1, 1'b0, `SCI_OP_PRE_ALL, MO);
    chk(bopen, 4'h0);
    op(`SCI_CMD_BURST_STOP, 13'($urandom), 2'b0, 1'b1, 1'b0, `SCI_OP_BURST_TERM, MO);
    op(`SCI_CMD_BURST_STOP, 13'($urandom), 2'b0, 1'b0, 1'b0, `SCI_OP_DEEP_PD, MO);
    chk(lp, 2'b01);
    op(`SCI_CMD_NOP, 13'($urandom), 2'b0, 1'b1, 1'b0, 4'h0, 20'h0);
    for (int i = 0; i < 3; i++) begin
      op(`SCI_CMD_REFRESH, 13'($urandom), 2'($urandom), 1'b1, 1'b0, `SCI_OP_AUTO_REF, MO);
      rc_m++;
      chk({lp, rcnt}, {2'b00, rc_m});
    end
    op(`SCI_CMD_REFRESH, 13'($urandom), 2'b0, 1'b0, 1'b0, `SCI_OP_SELF_REF, MO);
    chk(lp, 2'b10);
    op(`SCI_CMD_NOP, 13'($urandom), 2'b0, 1'b1, 1'b1, 4'h0, 20'h0);
    chk({lp, wmask, rhiz}, 4'h2);
    op(`SCI_CMD_NOP, 13'($urandom), 2'b0, 1'b1, 1'b1, 4'h0, 20'h0);
    op(`SCI_CMD_NOP, 13'($urandom), 2'b0, 1'b1, 1'b0, 4'h0, 20'h0);
    chk({wmask, rhiz}, 2'b01);
    drain;
    hold <= 1'b1;
    repeat (3) op(`SCI_CMD_BURST_STOP, 13'($urandom), 2'b0, 1'b1, 1'b0, `SCI_OP_BURST_TERM, MO);
    chk({valid, stall}, 2'b11);
    hold <= 1'b0;
    drain;
    @(negedge sys_clk_i);
    chk({valid, stall, 32'(expq.size())}, 34'h0);
    stop_test;
  end
endmodule // sci_command_interface_bench
